/* rtl/amon_top.v */
`timescale 1ns/100ps
// Operation
// - led shows highest active alarm code
// - non-latching alarm follows present violation
// - latching alarm holds until user clear
// - clear during violation re-latches at once
// - contact closes for contact-enabled active alarms
// - below low limit alarms, limit alarms only
// - above high limit alarms, limit alarms only
// - temperature defaults code 7, 5..60
// - valve drive defaults code 3, 0..99
// - power failure defaults code 6, state
// - any self-test failure raises red diagnostic
// - working memory test failure feeds diagnostic
// - nonvolatile and checksum failures feed diagnostic
// - per-test failure status readable by software
`include "amon_regs.vh"

module amon_top #(
	parameter NA = 4, // alarm channels
	parameter VW = 8, // monitored value width
	parameter CW = 4  // alarm code width
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata_q,
	output reg           pready_q,
	output reg           pslverr_q,
	input  wire [VW-1:0] temp_pct,
	input  wire [VW-1:0] valve_pct,
	input  wire          pwr_fail_pin,
	input  wire          ram_fail,
	input  wire          nvm_fail,
	input  wire          csum_fail,
	output reg  [CW-1:0] led_code_q,
	output reg           red_led_q,
	input  wire          contact_i,
	output reg           contact_o_q,
	output reg           contact_oe_q,
	output reg           irq_q
);

	// control and configuration registers
	reg  [31:0]      ctrl_q;        // latch and contact enables
	reg  [NA*CW-1:0] code_q;        // alarm codes, four bits each
	reg  [VW-1:0]    temp_lo_q;     // temperature low limit
	reg  [VW-1:0]    temp_hi_q;     // temperature high limit
	reg  [VW-1:0]    valve_lo_q;    // valve drive low limit
	reg  [VW-1:0]    valve_hi_q;    // valve drive high limit
	reg  [NA-1:0]    irq_stat_q;    // sticky rising-edge events
	reg  [NA-1:0]    irq_mask_q;    // interrupt enables
	reg  [NA-1:0]    ind_prev_q;    // indication one cycle back
	reg  [NA-1:0]    clear_q;       // one-cycle clear pulses

	// pin synchronisers
	reg              pwr_s1_q;      // power-fail first stage
	reg              pwr_s2_q;      // power-fail second stage
	reg              cin_s1_q;      // contact readback first stage
	reg              cin_s2_q;      // contact readback second stage

	// channel plumbing
	wire [NA*VW-1:0] val_flat;      // monitored values per channel
	wire [NA*VW-1:0] lo_flat;       // low limits per channel
	wire [NA*VW-1:0] hi_flat;       // high limits per channel
	wire [NA-1:0]    state_bad;     // state conditions per channel
	wire [NA-1:0]    cond;          // present violations
	wire [NA-1:0]    ind;           // indicated alarms
	wire [2:0]       diag_fail;     // held self-test status
	wire             diag_any;      // any self-test failed

	// bus decode
	wire             acc;           // access phase seen
	wire             wr_fire;       // write takes effect now
	wire             hit_ctrl;
	wire             hit_code;
	wire             hit_temp;
	wire             hit_valve;
	wire             hit_stat;
	wire             hit_diag;
	wire             hit_clr;
	wire             hit_istat;
	wire             hit_imask;
	wire             mapped;        // address decodes to a register

	// combinational results
	reg  [CW-1:0]    code_d;        // highest active code
	reg              contact_d;     // contact should close
	reg  [31:0]      rdata_d;       // read data mux
	integer          k;

	// power-fail arrives from a pin and crosses two flops first;
	// the contact readback takes the same path, and it resets high
	// because the pulled-up pin reads high while the contact is open,
	// so status shows no false closure straight after reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_s1_q <= 1'b0;
			pwr_s2_q <= 1'b0;
			cin_s1_q <= 1'b1;
			cin_s2_q <= 1'b1;
		end else begin
			pwr_s1_q <= pwr_fail_pin;
			pwr_s2_q <= pwr_s1_q;
			cin_s1_q <= contact_i;
			cin_s2_q <= cin_s1_q;
		end
	end

	// self-test status; software clears by writing ones to diag.
	// the clear strobe is gated with the write edge so a read of the
	// same word, or a stalled access phase, never loses a failure
	amon_diag #(
		.NT (3)
	) u_diag (
		.pclk     (pclk),
		.presetn  (presetn),
		.fail     ({csum_fail, nvm_fail, ram_fail}),
		.clr      (pwdata[2:0] & {3{wr_fire & hit_diag}}),
		.fail_q   (diag_fail),
		.any_fail (diag_any)
	);

	// channel inputs: values and limits only for limit channels.
	// state channels get zero values and limits; the compare inside
	// them is not built, so the zeros cost nothing and read cleanly
	assign val_flat[`AMON_CH_DIAG*VW +: VW]  = {VW{1'b0}};
	assign val_flat[`AMON_CH_TEMP*VW +: VW]  = temp_pct;
	assign val_flat[`AMON_CH_PWR*VW +: VW]   = {VW{1'b0}};
	assign val_flat[`AMON_CH_VALVE*VW +: VW] = valve_pct;
	assign lo_flat[`AMON_CH_DIAG*VW +: VW]   = {VW{1'b0}};
	assign lo_flat[`AMON_CH_TEMP*VW +: VW]   = temp_lo_q;
	assign lo_flat[`AMON_CH_PWR*VW +: VW]    = {VW{1'b0}};
	assign lo_flat[`AMON_CH_VALVE*VW +: VW]  = valve_lo_q;
	assign hi_flat[`AMON_CH_DIAG*VW +: VW]   = {VW{1'b0}};
	assign hi_flat[`AMON_CH_TEMP*VW +: VW]   = temp_hi_q;
	assign hi_flat[`AMON_CH_PWR*VW +: VW]    = {VW{1'b0}};
	assign hi_flat[`AMON_CH_VALVE*VW +: VW]  = valve_hi_q;
	assign state_bad[`AMON_CH_DIAG]          = diag_any;
	assign state_bad[`AMON_CH_TEMP]          = 1'b0;
	assign state_bad[`AMON_CH_PWR]           = pwr_s2_q;
	assign state_bad[`AMON_CH_VALVE]         = 1'b0;

	// one channel per alarm; temperature and valve compare limits.
	// every channel owns one latch enable bit and one clear bit,
	// indexed by channel number, so adding a channel only needs a
	// new entry in the input plumbing above
	genvar gi;
	generate
		for (gi = 0; gi < NA; gi = gi + 1) begin : g_ch
			amon_chan #(
				.IS_LIMIT ((gi == `AMON_CH_TEMP) || (gi == `AMON_CH_VALVE)),
				.VW       (VW)
			) u_chan (
				.pclk      (pclk),
				.presetn   (presetn),
				.value     (val_flat[gi*VW +: VW]),
				.lim_lo    (lo_flat[gi*VW +: VW]),
				.lim_hi    (hi_flat[gi*VW +: VW]),
				.state_bad (state_bad[gi]),
				.latch_en  (ctrl_q[`AMON_CTRL_LATCH_LSB + gi]),
				.clear     (clear_q[gi]),
				.cond      (cond[gi]),
				.ind_q     (ind[gi])
			);
		end
	endgenerate

	// highest code among active alarms; equal codes are harmless.
	// strict greater-than keeps the first of two equal codes, which
	// gives the same value on the led either way.
	// contact uses the indication, so a latched alarm keeps the
	// contact closed until it is cleared
	always @* begin
		code_d    = {CW{1'b0}};
		contact_d = 1'b0;
		for (k = 0; k < NA; k = k + 1) begin
			if (ind[k] && (code_q[k*CW +: CW] > code_d)) begin
				code_d = code_q[k*CW +: CW];
			end
			if (ind[k] && ctrl_q[`AMON_CTRL_CONTACT_LSB + k]) begin
				contact_d = 1'b1;
			end
		end
	end

	// indicator and contact outputs, all registered.
	// the extra flop costs one cycle of latency but keeps the pins
	// free of glitches from the priority search above
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_code_q   <= {CW{1'b0}};
			red_led_q    <= 1'b0;
			contact_o_q  <= 1'b0;
			contact_oe_q <= 1'b0;
			irq_q        <= 1'b0;
		end else begin
			led_code_q   <= code_d;
			red_led_q    <= ind[`AMON_CH_DIAG];
			contact_o_q  <= 1'b0;                  // open collector pulls low
			contact_oe_q <= contact_d;
			irq_q        <= |(irq_stat_q & irq_mask_q);
		end
	end

	// apb decode; slave answers on the second access cycle
	assign acc       = psel & penable;
	assign wr_fire   = acc & pready_q & pwrite;
	assign hit_ctrl  = (paddr == `AMON_CTRL_OFS);
	assign hit_code  = (paddr == `AMON_CODE_OFS);
	assign hit_temp  = (paddr == `AMON_TEMP_LIM_OFS);
	assign hit_valve = (paddr == `AMON_VALVE_LIM_OFS);
	assign hit_stat  = (paddr == `AMON_STATUS_OFS);
	assign hit_diag  = (paddr == `AMON_DIAG_OFS);
	assign hit_clr   = (paddr == `AMON_CLEAR_OFS);
	assign hit_istat = (paddr == `AMON_IRQ_STAT_OFS);
	assign hit_imask = (paddr == `AMON_IRQ_MASK_OFS);
	assign mapped    = hit_ctrl | hit_code | hit_temp | hit_valve | hit_stat |
	                   hit_diag | hit_clr | hit_istat | hit_imask;

	// read mux; write-only and unmapped words read as zero
	always @* begin
		rdata_d = 32'h0000_0000;
		case (1'b1)
			hit_ctrl: begin
				rdata_d = ctrl_q;
			end
			hit_code: begin
				rdata_d[NA*CW-1:0] = code_q;
			end
			hit_temp: begin
				rdata_d[`AMON_LIM_LO_LSB +: VW] = temp_lo_q;
				rdata_d[`AMON_LIM_HI_LSB +: VW] = temp_hi_q;
			end
			hit_valve: begin
				rdata_d[`AMON_LIM_LO_LSB +: VW] = valve_lo_q;
				rdata_d[`AMON_LIM_HI_LSB +: VW] = valve_hi_q;
			end
			hit_stat: begin
				rdata_d[`AMON_STAT_IND_LSB +: NA]  = ind;
				rdata_d[`AMON_STAT_COND_LSB +: NA] = cond;
				rdata_d[`AMON_STAT_CODE_LSB +: CW] = led_code_q;
				rdata_d[`AMON_STAT_CONTACT_BIT]    = contact_oe_q;
				rdata_d[`AMON_STAT_PIN_BIT]        = cin_s2_q;
				rdata_d[`AMON_STAT_RED_BIT]        = red_led_q;
			end
			hit_diag: begin
				rdata_d[2:0] = diag_fail;
			end
			hit_istat: begin
				rdata_d[NA-1:0] = irq_stat_q;
			end
			hit_imask: begin
				rdata_d[NA-1:0] = irq_mask_q;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// apb handshake: one wait cycle, then pready for one cycle.
	// read data is captured in the wait cycle and zeroed otherwise,
	// so a stale word never sits on the bus between transfers;
	// pready dropping after one cycle lets a master start the
	// next setup phase directly after the answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc & ~pready_q;
			pslverr_q <= acc & ~pready_q & ~mapped;
			if (acc && !pready_q && !pwrite) begin
				prdata_q <= rdata_d;
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// configuration writes; reset gives the documented defaults
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= `AMON_CTRL_RST;
			code_q     <= `AMON_CODE_RST;
			temp_lo_q  <= `AMON_TEMP_LO_RST;
			temp_hi_q  <= `AMON_TEMP_HI_RST;
			valve_lo_q <= `AMON_VALVE_LO_RST;
			valve_hi_q <= `AMON_VALVE_HI_RST;
			irq_mask_q <= `AMON_MASK_RST;
		end else if (wr_fire) begin
			if (hit_ctrl) begin
				ctrl_q <= pwdata;
			end
			if (hit_code) begin
				code_q <= pwdata[NA*CW-1:0];
			end
			if (hit_temp) begin
				temp_lo_q <= pwdata[`AMON_LIM_LO_LSB +: VW];
				temp_hi_q <= pwdata[`AMON_LIM_HI_LSB +: VW];
			end
			if (hit_valve) begin
				valve_lo_q <= pwdata[`AMON_LIM_LO_LSB +: VW];
				valve_hi_q <= pwdata[`AMON_LIM_HI_LSB +: VW];
			end
			if (hit_imask) begin
				irq_mask_q <= pwdata[NA-1:0];
			end
		end
	end

	// clear pulses last exactly one cycle after the write edge.
	// a channel with a live violation re-latches in that cycle, so
	// software may clear blindly and read status to see what stays
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_q <= {NA{1'b0}};
		end else if (wr_fire && hit_clr) begin
			clear_q <= pwdata[NA-1:0];
		end else begin
			clear_q <= {NA{1'b0}};
		end
	end

	// interrupt events: a new indication sets its bit; set beats w1c.
	// only rising indications count, so a held alarm raises one event
	// and not a stream of them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_prev_q <= {NA{1'b0}};
			irq_stat_q <= {NA{1'b0}};
		end else begin
			ind_prev_q <= ind;
			if (wr_fire && hit_istat) begin
				irq_stat_q <= (ind & ~ind_prev_q) | (irq_stat_q & ~pwdata[NA-1:0]);
			end else begin
				irq_stat_q <= (ind & ~ind_prev_q) | irq_stat_q;
			end
		end
	end

endmodule

/* rtl/amon_regs.vh */
`ifndef AMON_REGS_VH
`define AMON_REGS_VH

// register byte offsets
`define AMON_CTRL_OFS      12'h000
`define AMON_CODE_OFS      12'h004
`define AMON_TEMP_LIM_OFS  12'h008
`define AMON_VALVE_LIM_OFS 12'h00c
`define AMON_STATUS_OFS    12'h010
`define AMON_DIAG_OFS      12'h014
`define AMON_CLEAR_OFS     12'h018
`define AMON_IRQ_STAT_OFS  12'h01c
`define AMON_IRQ_MASK_OFS  12'h020

// alarm channel indices
`define AMON_CH_DIAG  0
`define AMON_CH_TEMP  1
`define AMON_CH_PWR   2
`define AMON_CH_VALVE 3

// control register fields
`define AMON_CTRL_LATCH_LSB   0
`define AMON_CTRL_CONTACT_LSB 8

// limit register fields
`define AMON_LIM_LO_LSB 0
`define AMON_LIM_HI_LSB 8

// status register fields
`define AMON_STAT_IND_LSB     0
`define AMON_STAT_COND_LSB    8
`define AMON_STAT_CODE_LSB    16
`define AMON_STAT_CONTACT_BIT 20
`define AMON_STAT_PIN_BIT     21
`define AMON_STAT_RED_BIT     22

// reset values
`define AMON_CTRL_RST      32'h0000_0f00
`define AMON_CODE_RST      16'h367c
`define AMON_TEMP_LO_RST   8'h05
`define AMON_TEMP_HI_RST   8'h3c
`define AMON_VALVE_LO_RST  8'h00
`define AMON_VALVE_HI_RST  8'h63
`define AMON_MASK_RST      4'h0

// answer latency of the bus slave, in access cycles
`define AMON_WAIT_CYCLES   1

`endif

/* rtl/amon_chan.v */
`timescale 1ns/100ps
// one alarm channel: limit or state compare plus optional latch
module amon_chan #(
	parameter IS_LIMIT = 1,  // 1 limit-monitoring, 0 state-monitoring
	parameter VW       = 8   // width of monitored value
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire [VW-1:0] value,       // monitored value, percent
	input  wire [VW-1:0] lim_lo,      // low limit
	input  wire [VW-1:0] lim_hi,      // high limit
	input  wire          state_bad,   // state condition for state alarms
	input  wire          latch_en,    // latching attribute
	input  wire          clear,       // one-cycle user clear
	output wire          cond,        // present violation
	output reg           ind_q        // indicated alarm
);

	reg ind_d; // next indication

	// limits only matter for limit alarms; state alarms ignore them
	generate
		if (IS_LIMIT != 0) begin : g_lim
			assign cond = (value < lim_lo) | (value > lim_hi);
		end else begin : g_state
			assign cond = state_bad;
		end
	endgenerate

	// latch logic: present violation always wins, so a clear during
	// a live violation re-latches in the same cycle
	always @* begin
		if (latch_en) begin
			ind_d = cond | (ind_q & ~clear);
		end else begin
			ind_d = cond;
		end
	end

	// indication flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_q <= 1'b0;
		end else begin
			ind_q <= ind_d;
		end
	end

endmodule

/* rtl/amon_diag.v */
`timescale 1ns/100ps
// sticky per-test self-test failure status
module amon_diag #(
	parameter NT = 3 // number of self-tests
) (
	input  wire          pclk,
	input  wire          presetn,
	input  wire [NT-1:0] fail,     // failure reports, one bit per test
	input  wire [NT-1:0] clr,      // write-one-to-clear strobes
	output reg  [NT-1:0] fail_q,   // held failure status
	output wire          any_fail  // feeds the diagnostic alarm
);

	// a new failure in the clear cycle is kept: set beats clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_q <= {NT{1'b0}};
		end else begin
			fail_q <= fail | (fail_q & ~clr);
		end
	end

	assign any_fail = |fail_q;

endmodule

/* verif/amon_top_sva.sv */
`timescale 1ns/100ps
// port-level checks of the alarm block
module amon_top_sva #(
	parameter VW = 8,
	parameter CW = 4
) (
	input wire          pclk,
	input wire          presetn,
	input wire          psel,
	input wire          penable,
	input wire          pwrite,
	input wire [11:0]   paddr,
	input wire [VW-1:0] temp_pct,
	input wire [VW-1:0] valve_pct,
	input wire          pwr_fail_pin,
	input wire          ram_fail,
	input wire          nvm_fail,
	input wire          csum_fail,
	input wire          pready_q,
	input wire          pslverr_q,
	input wire [CW-1:0] led_code_q,
	input wire          red_led_q,
	input wire          contact_o_q,
	input wire          contact_oe_q,
	input wire          irq_q
);
	reg  dflt_q; // no ctrl, code or limit write since reset
	wire quiet;  // all inputs inside default limits
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign quiet = temp_pct >= 8'h05 && temp_pct <= 8'h3c && valve_pct <= 8'h63
		&& !pwr_fail_pin && !ram_fail && !nvm_fail && !csum_fail;
	// limit checks below only hold with reset defaults
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dflt_q <= 1'b1;
		else if (psel && penable && pready_q && pwrite && paddr < 12'h010)
			dflt_q <= 1'b0;
	end
	a_temp_high: assert property (dflt_q && temp_pct > 8'h3c |-> ##2 led_code_q >= 4'h7)
		else $error("temperature above limit not shown");
	a_temp_low: assert property (dflt_q && temp_pct < 8'h05 |-> ##2 led_code_q >= 4'h7)
		else $error("temperature below limit not shown");
	a_valve_high: assert property (dflt_q && valve_pct > 8'h63 |-> ##2 contact_oe_q)
		else $error("valve above limit left contact open");
	a_code_max: assert property (dflt_q && temp_pct > 8'h3c && valve_pct > 8'h63
		|-> ##2 (led_code_q == 4'h7 || led_code_q == 4'hc)) else $error("lower code shown");
	a_idle_zero: assert property ((dflt_q && quiet) [*5] ##0 !red_led_q
		|=> led_code_q == 4'h0 && !contact_oe_q) else $error("alarm shown while quiet");
	a_diag_red: assert property (dflt_q && (ram_fail || nvm_fail || csum_fail)
		|-> ##[2:4] (red_led_q && led_code_q == 4'hc)) else $error("self-test fail unseen");
	a_apb_answer: assert property (psel && !penable ##1 psel && penable |=> pready_q)
		else $error("bus answer late");
	a_unmapped_err: assert property (psel && penable && pready_q
		|-> pslverr_q == (paddr > 12'h020 || paddr[1:0] != 2'h0)) else $error("bad error flag");
	a_contact_low: assert property (!contact_o_q)
		else $error("contact driven high");
	cover property (red_led_q);
	cover property (irq_q);
	cover property (pslverr_q);
endmodule

bind amon_top amon_top_sva #(.VW(VW), .CW(CW)) amon_top_sva_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .temp_pct, .valve_pct, .pwr_fail_pin, .ram_fail, .nvm_fail,
	.csum_fail, .pready_q, .pslverr_q, .led_code_q, .red_led_q, .contact_o_q,
	.contact_oe_q, .irq_q);

/* verif/amon_proc_model.sv */
`timescale 1ns/100ps
// far side: process values, self-test reports, contact wire
module amon_proc_model (
	input  wire       pclk,
	input  wire       contact_oe_q,
	output reg  [7:0] temp_pct,
	output reg  [7:0] valve_pct,
	output reg        pwr_fail_pin,
	output reg  [2:0] fails,
	output wire       contact_i
);
	// pulled up, low only while the block sinks it
	assign contact_i = ~contact_oe_q;
	initial begin
		temp_pct = 8'h14;
		valve_pct = 8'h32;
		pwr_fail_pin = 1'b0;
		fails = 3'h0;
	end
	// new values land just after a rising edge
	task put(input [7:0] t, input [7:0] v, input p, input [2:0] f);
		begin
			@(posedge pclk);
			temp_pct <= t;
			valve_pct <= v;
			pwr_fail_pin <= p;
			fails <= f;
		end
	endtask
endmodule

/* verif/amon_top_tb_top.sv */
`timescale 1ns/100ps
`include "amon_regs.vh"
// self-checking bench for the alarm block
module amon_top_tb_top;
	reg         pclk;
	reg         presetn;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg  [11:0] paddr;
	reg  [31:0] pwdata;
	wire [31:0] prdata_q;
	wire        pready_q;
	wire        pslverr_q;
	wire [7:0]  temp_pct;
	wire [7:0]  valve_pct;
	wire        pwr_fail_pin;
	wire [2:0]  fails;      // ram, nvm, checksum
	wire [3:0]  led_code_q;
	wire        red_led_q;
	wire        contact_i;
	wire        contact_o_q;
	wire        contact_oe_q;
	wire        irq_q;
	reg  [31:0] rd;         // last read word
	reg         er;         // last error flag
	integer     n_mismatch;
	integer     tests_run;
	integer     cyc = 0;    // watchdog count
	integer     i;
	amon_top amon_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata_q, .pready_q, .pslverr_q, .temp_pct, .valve_pct, .pwr_fail_pin,
		.ram_fail(fails[0]), .nvm_fail(fails[1]), .csum_fail(fails[2]), .led_code_q,
		.red_led_q, .contact_i, .contact_o_q, .contact_oe_q, .irq_q);
	amon_proc_model amon_proc_model_i (.pclk, .contact_oe_q, .temp_pct, .valve_pct,
		.pwr_fail_pin, .fails, .contact_i);
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;
	// a hang ends the run as a failure
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			give_verdict;
		end
	end
	task give_verdict;
		begin
			$display("counts: %0d compared, %0d bad", tests_run, n_mismatch);
			if (n_mismatch == 0 && tests_run > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	// one transfer, held until pready is seen at an edge
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready_q !== 1'b1)
				@(posedge pclk);
			rd = prdata_q;
			er = pslverr_q;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rc(input [11:0] a, input [31:0] e);
		begin
			apb(1'b0, a, 32'h0);
			chk(rd, e);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task settle(input integer n);
		begin
			repeat (n) @(posedge pclk);
			@(negedge pclk);
		end
	endtask
	// contacts all enabled unless a test says otherwise
	task lim(input [7:0] t, input [7:0] v, input [3:0] e);
		begin
			amon_proc_model_i.put(t, v, 1'b0, 3'h0);
			settle(5);
			chk(led_code_q, e);
			chk(contact_oe_q, e != 4'h0);
		end
	endtask
	task rst;
		begin
			@(posedge pclk);
			presetn <= 1'b0;
			repeat (10) @(posedge pclk);
			presetn <= 1'b1;
		end
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_mismatch = 0;
		tests_run = 0;
		rst;
		rc(`AMON_CTRL_OFS, 32'h0000_0f00);
		rc(`AMON_CODE_OFS, 32'h0000_367c);
		rc(`AMON_TEMP_LIM_OFS, 32'h0000_3c05);
		rc(`AMON_VALVE_LIM_OFS, 32'h0000_6300);
		rc(`AMON_IRQ_MASK_OFS, 32'h0);
		rc(12'h040, 32'h0);
		chk(er, 1'b1);
		wr(12'h040, 32'hffff_ffff);
		rc(`AMON_CTRL_OFS, 32'h0000_0f00);
		$display("test reset values done");
		lim(8'h14, 8'h32, 4'h0);
		lim(8'h04, 8'h32, 4'h7);
		lim(8'h05, 8'h32, 4'h0);
		lim(8'h3d, 8'h32, 4'h7);
		rc(`AMON_STATUS_OFS, 32'h0017_0202);
		lim(8'h3c, 8'h00, 4'h0);
		lim(8'h14, 8'h64, 4'h3);
		lim(8'h3d, 8'h64, 4'h7);
		lim(8'h14, 8'h63, 4'h0);
		amon_proc_model_i.put(8'h14, 8'h32, 1'b1, 3'h0);
		settle(5);
		rc(`AMON_STATUS_OFS, 32'h0016_0404);
		lim(8'h14, 8'h32, 4'h0);
		$display("test limits done");
		// each self-test pulses once, then is cleared by software
		for (i = 0; i < 3; i = i + 1) begin
			amon_proc_model_i.put(8'h14, 8'h32, 1'b0, 3'h1 << i);
			amon_proc_model_i.put(8'h14, 8'h32, 1'b0, 3'h0);
			settle(4);
			chk({red_led_q, led_code_q}, 5'h1c);
			rc(`AMON_DIAG_OFS, 32'h1 << i);
			wr(`AMON_DIAG_OFS, 32'h1 << i);
			settle(4);
			chk({red_led_q, led_code_q}, 5'h00);
		end
		$display("test diagnostics done");
		wr(`AMON_IRQ_STAT_OFS, 32'hf);
		wr(`AMON_IRQ_MASK_OFS, 32'h2);
		lim(8'h46, 8'h32, 4'h7);
		chk(irq_q, 1'b1);
		wr(`AMON_IRQ_MASK_OFS, 32'h0);
		settle(1);
		chk(irq_q, 1'b0);
		wr(`AMON_IRQ_MASK_OFS, 32'h2);
		settle(1);
		chk(irq_q, 1'b1);
		rc(`AMON_IRQ_STAT_OFS, 32'h2);
		wr(`AMON_IRQ_STAT_OFS, 32'h2);
		settle(1);
		chk(irq_q, 1'b0);
		lim(8'h14, 8'h32, 4'h0);
		$display("test interrupt done");
		rst;
		wr(`AMON_CTRL_OFS, 32'h0000_0f02);
		lim(8'h46, 8'h32, 4'h7);
		lim(8'h14, 8'h32, 4'h7);
		amon_proc_model_i.put(8'h46, 8'h32, 1'b0, 3'h0);
		wr(`AMON_CLEAR_OFS, 32'h2);
		// no gap allowed while the violation persists
		repeat (4) begin
			@(negedge pclk);
			chk(led_code_q, 4'h7);
		end
		lim(8'h14, 8'h32, 4'h7);
		wr(`AMON_CLEAR_OFS, 32'h2);
		settle(2);
		chk(led_code_q, 4'h0);
		$display("test latching done");
		wr(`AMON_CTRL_OFS, 32'h0000_0d00);
		wr(`AMON_CODE_OFS, 32'h0000_962c);
		lim(8'h46, 8'h64, 4'h9);
		amon_proc_model_i.put(8'h46, 8'h32, 1'b0, 3'h0);
		settle(5);
		chk({contact_oe_q, led_code_q}, 5'h02);
		rc(`AMON_STATUS_OFS, 32'h0022_0202);
		$display("test codes and contact done");
		give_verdict;
	end
endmodule
